/* File: sps_sequencer.sv */
/*
 Stepper phase sequencer: an eight-state translator with step, direction
 and step-size pins, an enable pin, and an APB slave for control and status.
 Assumes the enable and APB pins are synchronous to pclk and an APB master on the bus.
*/
// Local design decisions: register access over APB and the register offsets.
// Summary of operation
// R1: Bipolar wave drive: AB, CD, BA, DC.
// R2: Two-phase-on keeps both phases energized.
// R3: Half step alternates one and two phases.
// R4: Counter-clockwise walks sequences in reverse.
// R5: Reluctance wave drive: A, C, B, D.
// R6: Reluctance two-phase: AC, CB, BD, DA.
// R7: Reluctance half step: eight-state winding walk.
// R8: Each bridge gets two phases plus enable.
// R9: Unipolar stages use the bipolar sequences.
// R10: Three-bit counter walks the half step sequence.
// R11: Full step skips the counter's low bit.
// R12: Reset gives state one, ABCD 0101, home. The code resets drive to 0; 0101 follows on the first clock after reset.
// R13: Enable low forces phases and inhibits low.
// R14: One state advanced per step pulse.
// R15: Inputs synchronized; act on step rising edge. drive_enable enters unsynchronized.
`timescale 1ns/100ps
module sps_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic step_pulse,
   input wire logic rotation_direction,
   input wire logic half_step_select,
   input wire logic drive_enable,
   output sps_pkg::sps_drive_t drive,
   output logic home
);
   import sps_pkg::*;

   // ------------------------------------------------------------
   // Input synchronizers and step edge.
   // ------------------------------------------------------------
   logic [2:0] sync1, sync2, next_sync1, next_sync2;
   logic step_d, next_step_d, step_edge;
   logic dir_s, half_s;

   always_comb begin
      next_sync1 = {step_pulse, rotation_direction, half_step_select};
      next_sync2 = sync1;
      next_step_d = sync2[2];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         step_d <= 1'b0;
      end else begin
         sync1 <= next_sync1; // [R15]
         sync2 <= next_sync2;
         step_d <= next_step_d;
      end
   end

   assign dir_s = sync2[1];
   assign half_s = sync2[0];

   // ------------------------------------------------------------
   // APB slave.
   // ------------------------------------------------------------
   logic [1:0] ctrl, next_ctrl;
   logic sw_step, next_sw_step;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, acc, done, mapped;
   logic [2:0] cnt, next_cnt;

   assign acc = psel && penable && !pready;
   assign done = psel && penable && pready;
   assign step_edge = (sync2[2] && !step_d) || sw_step; // [R15]

   always_comb begin
      next_ctrl = ctrl;
      next_sw_step = 1'b0;
      next_prdata = prdata;
      next_pready = acc;
      next_pslverr = 1'b0;
      mapped = (paddr == SPS_CTRL_ADDR) || (paddr == SPS_STEP_ADDR) || (paddr == SPS_STAT_ADDR && !pwrite);
      if (acc) begin
         next_pslverr = !mapped;
         case (paddr)
            SPS_CTRL_ADDR: next_prdata = {30'h0, ctrl};
            SPS_STAT_ADDR: next_prdata = {22'h0, drive.bridge2_inhibit, drive.bridge1_inhibit, home,
                                          drive.a, drive.b, drive.c, drive.d, cnt};
            default: next_prdata = 32'h0;
         endcase
      end
      if (done && pwrite && !pslverr) begin
         if (paddr == SPS_CTRL_ADDR) next_ctrl = pwdata[1:0];
         if (paddr == SPS_STEP_ADDR) next_sw_step = pwdata[SPS_STEP_GO_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= SPS_CTRL_RESET;
         sw_step <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         sw_step <= next_sw_step;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ------------------------------------------------------------
   // Translator and output logic.
   // ------------------------------------------------------------
   function automatic logic [3:0] sps_phase(input logic [2:0] st, input logic vr);
      logic [31:0] tbl;
      tbl = vr ? SPS_VR_TABLE : SPS_PM_TABLE; // [R5] [R6] [R7] [R9]
      sps_phase = tbl[{st, 2'h0} +: 4];
   endfunction

   logic en_eff, vr;
   logic [2:0] inc;
   logic [3:0] ph;
   sps_drive_t next_drive;
   logic next_home;

   assign en_eff = drive_enable && ctrl[SPS_CTRL_EN_BIT];
   assign vr = ctrl[SPS_CTRL_VR_BIT];

   always_comb begin
      inc = half_s ? SPS_HALF_INC : SPS_FULL_INC; // [R10] [R11]
      next_cnt = cnt;
      if (step_edge) begin
         next_cnt = dir_s ? cnt + inc : cnt - inc; // [R4] [R14]
      end
      ph = sps_phase(next_cnt, vr); // [R1] [R2] [R3]
      next_drive = '0;
      if (en_eff) begin
         next_drive.a = ph[3];
         next_drive.b = ph[2];
         next_drive.c = ph[1];
         next_drive.d = ph[0];
         next_drive.bridge1_inhibit = ph[3] | ph[2]; // [R8]
         next_drive.bridge2_inhibit = ph[1] | ph[0];
      end
      next_home = (next_cnt == SPS_HOME_STATE); // [R12]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= SPS_HOME_STATE; // [R12]
         drive <= '0;
         home <= 1'b1;
      end else begin
         cnt <= next_cnt;
         drive <= next_drive; // [R13]
         home <= next_home;
      end
   end

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_step_half;
      step_edge && half_s;
   endsequence
   sequence s_step_full;
      step_edge && !half_s;
   endsequence

   chk_home_flag: assert property (home == (cnt == SPS_HOME_STATE)) else $error("home flag wrong"); // [R12]
   chk_enable_off: assert property (!en_eff |=> drive == '0) else $error("outputs not forced low"); // [R13]
   chk_half_cw: assert property (s_step_half ##0 dir_s |=> cnt == $past(cnt) + 3'h1) // [R10] [R14]
      else $error("half step cw wrong");
   chk_half_ccw: assert property (s_step_half ##0 !dir_s |=> cnt == $past(cnt) - 3'h1) // [R4]
      else $error("half step ccw wrong");
   chk_full_lsb: assert property (s_step_full |=> cnt[0] == $past(cnt[0]) && cnt != $past(cnt)) // [R11]
      else $error("full step touched low bit");
   chk_no_step_hold: assert property (!step_edge |=> $stable(cnt)) else $error("state moved without step"); // [R14]
   chk_pm_two_on: assert property ($past(presetn) && $past(en_eff) && !$past(vr) && !cnt[0] |-> // [R2]
      (drive.a ^ drive.b) && (drive.c ^ drive.d)) else $error("two phase state wrong");
   chk_pm_one_on: assert property ($past(presetn) && $past(en_eff) && !$past(vr) && cnt[0] |-> // [R1] [R3]
      ((drive.a | drive.b) ^ (drive.c | drive.d))) else $error("one phase state wrong");
   chk_vr_single: assert property ($past(presetn) && $past(en_eff) && $past(vr) && cnt[0] |-> // [R5]
      $onehot({drive.a, drive.b, drive.c, drive.d})) else $error("reluctance single winding wrong");
   chk_vr_pair: assert property ($past(presetn) && $past(en_eff) && $past(vr) && !cnt[0] |-> // [R6] [R7]
      $countones({drive.a, drive.b, drive.c, drive.d}) == 2) else $error("reluctance pair wrong");
   chk_inhibit_or: assert property ($past(en_eff) |-> drive.bridge1_inhibit == (drive.a | drive.b) // [R8]
      && drive.bridge2_inhibit == (drive.c | drive.d)) else $error("inhibit mismatch");
   chk_step_sync: assert property (!sync2[2] ##1 sync2[2] && !sw_step |-> step_edge) // [R15]
      else $error("step edge missed");
   chk_level_once: assert property (sync2[2] && step_d && !sw_step |-> !step_edge) // [R15]
      else $error("held step level acted again");

   // ------------------------------------------------------------
   // Assertions on the register bus.
   // ------------------------------------------------------------
   sequence s_apb_write;
      done && pwrite && !pslverr;
   endsequence

   chk_apb_wait: assert property (acc |=> pready ##1 !pready) else $error("apb answer timing wrong");
   chk_ctrl_write: assert property (s_apb_write ##0 paddr == SPS_CTRL_ADDR |=> ctrl == $past(pwdata[1:0])) // [R13]
      else $error("control write lost");
   chk_sw_step: assert property (s_apb_write ##0 (paddr == SPS_STEP_ADDR && pwdata[SPS_STEP_GO_BIT]) |=> step_edge) // [R14]
      else $error("software step lost");
   chk_apb_error: assert property (acc && !mapped |=> pready && pslverr)
      else $error("unmapped access not refused");
endmodule // sps_sequencer

/* File: sps_pkg.sv */
/*
 Package for the stepper phase sequencer: register map, field positions,
 reset values and the phase tables of the eight-state master sequence.
 Assumes a 32-bit APB register bus and one synchronous clock.
*/
package sps_pkg;
   // ------------------------------------------------------------
   // Register map and fields.
   // ------------------------------------------------------------
   localparam logic [7:0] SPS_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SPS_STEP_ADDR = 8'h04;
   localparam logic [7:0] SPS_STAT_ADDR = 8'h08;
   localparam int SPS_CTRL_EN_BIT = 0;
   localparam int SPS_CTRL_VR_BIT = 1;
   localparam int SPS_STEP_GO_BIT = 0;
   localparam logic [1:0] SPS_CTRL_RESET = 2'h1;
   localparam logic [2:0] SPS_HOME_STATE = 3'h0;
   localparam logic [2:0] SPS_HALF_INC = 3'h1;
   localparam logic [2:0] SPS_FULL_INC = 3'h2;

   // ------------------------------------------------------------
   // Types.
   // ------------------------------------------------------------
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
      logic bridge1_inhibit;
      logic bridge2_inhibit;
   } sps_drive_t;

   // ------------------------------------------------------------
   // Phase tables, ABCD from bit 3 down, indexed by state minus one.
   // ------------------------------------------------------------
   localparam logic [31:0] SPS_PM_TABLE = 32'h462a_8915;
   localparam logic [31:0] SPS_VR_TABLE = 32'h462a_8915;
endpackage

/* File: sps_bridge_model.sv */
/*
 Bridge driver model: turns phase and bridge enable lines into winding states.
 Assumes the sequencer drive struct on its input.
*/
`timescale 1ns/100ps
module sps_bridge_model (
   input wire sps_pkg::sps_drive_t drive,
   output logic [1:0] wind1,
   output logic [1:0] wind2
);
   import sps_pkg::*;
   // Each bridge needs its enable; 01 forward, 10 reverse, 00 or 11 no current.
   assign wind1 = drive.bridge1_inhibit ? {drive.b, drive.a} : 2'h0;
   assign wind2 = drive.bridge2_inhibit ? {drive.d, drive.c} : 2'h0;
endmodule // sps_bridge_model

/* File: stepper_phase_sequencer_tb.sv */
/*
 Testbench for the stepper phase sequencer with a bridge model at its drive.
 Assumes an APB slave that answers before the watchdog runs out.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module stepper_phase_sequencer_tb;
   import sps_pkg::*;
   localparam logic [31:0] TBL = 32'h462a_8915;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, home, step_pulse = 0, dir = 1, half = 1, en = 1;
   logic [1:0] w1, w2;
   logic [3:0] n;
   logic [5:0] exp6;
   logic [31:0] xs;
   sps_drive_t drive;
   int fails = 0, n_tests = 0, cnt = 0;
   sps_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_pulse(step_pulse), .rotation_direction(dir),
      .half_step_select(half), .drive_enable(en), .drive(drive), .home(home));
   sps_bridge_model far (.drive(drive), .wind1(w1), .wind2(w2));
   initial forever #12.5 pclk = ~pclk;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic stp(input logic d, input logic h);
      @(posedge pclk);
      dir <= d;
      half <= h;
      repeat (3) @(posedge pclk);
      step_pulse <= 1'b1;
      @(posedge pclk);
      step_pulse <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      cnt = (cnt + (d ? 1 : -1) * (h ? 1 : 2)) & 7;
   endtask
   task automatic cdrv();
      n = TBL[cnt*4 +: 4];
      exp6 = en ? {n, |n[3:2], |n[1:0]} : 6'h0;
      `CHK(drive, exp6)
      `CHK(home, 1'(cnt == 0))
   endtask
   task report_and_stop();
      $display("comparisons=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge pclk);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      cdrv();
      apb(1'b0, SPS_CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h1)
      for (int i = 0; i < 8; i++) begin
         stp(1'b1, 1'b1);
         cdrv();
      end
      stp(1'b0, 1'b1);
      cdrv();
      for (int i = 0; i < 4; i++) begin
         stp(1'b1, 1'b0);
         cdrv();
         `CHK(2'(^w1) + 2'(^w2), 2'h1)
      end
      stp(1'b1, 1'b1);
      for (int i = 0; i < 4; i++) begin
         stp(1'b0, 1'b0);
         cdrv();
         `CHK(^w1 & ^w2, 1'b1)
      end
      @(posedge pclk);
      en <= 1'b0;
      repeat (2) @(negedge pclk);
      cdrv();
      @(posedge pclk);
      en <= 1'b1;
      apb(1'b1, SPS_CTRL_ADDR, 32'h3);
      for (int i = 0; i < 8; i++) begin
         stp(1'b1, 1'b1);
         cdrv();
      end
      for (int i = 0; i < 4; i++) begin
         stp(1'b1, 1'b0);
         cdrv();
         `CHK(3'($countones(drive[5:2])), 3'h2)
      end
      stp(1'b1, 1'b1);
      for (int i = 0; i < 4; i++) begin
         stp(1'b1, 1'b0);
         cdrv();
         `CHK(3'($countones(drive[5:2])), 3'h1)
      end
      apb(1'b1, SPS_STEP_ADDR, 32'h1);
      repeat (2) @(negedge pclk);
      cnt = (cnt + (half ? 1 : 2)) & 7;
      cdrv();
      apb(1'b0, SPS_STAT_ADDR, 32'h0);
      xs = {22'h0, |n[1:0], |n[3:2], 1'(cnt == 0), n, 3'(cnt)};
      `CHK(rd, xs)
      apb(1'b1, 8'h0c, 32'h1);
      `CHK(er, 1'b1)
      repeat (2) @(negedge pclk);
      cdrv();
      report_and_stop();
   end
endmodule // stepper_phase_sequencer_tb
